/* pprc_button.sv */
/*
 * Model of the external button or driver on the general-purpose pins.
 * Assumes the bench asks for presses and holds them as long as it wants.
 */
`timescale 1ns/1ps

module pprc_button #(
	parameter int N_GPIO = 12
) (
	// Command from the bench
	input wire logic press,
	input wire logic [3:0] pin_sel,
	input wire logic active_high,
	// Pin levels
	output logic [N_GPIO-1:0] gpio
);
	// Idle pins rest at the inactive level, as with a pull resistor
	always_comb begin
		gpio = {N_GPIO{~active_high}};
		if (press) begin
			gpio[pin_sel] = active_high;
		end
	end
endmodule

/* pprc_ctrl.sv */
/*
 * Pin reset and pin power-on reset controller with its AHB-Lite register slave.
 * Assumes general-purpose pin levels and the slow RC oscillator arrive asynchronously
 * and are synchronised here; reset requests are consumed by the chip's reset logic.
 */
// Implementation choices: register access over AHB-Lite and the address map.
// Behaviour
// - Hardware reset comes only from the fixed reset pin, never any other pin.
// - Writing one to hw_reset_pin_off makes the fixed pin ordinary and ignored.
// - Power-on reset source pin is any general-purpose pin, picked by a select field.
// - A polarity bit decides whether high or low on that pin requests reset.
// - Required hold time is programmed time times 4096 slow RC periods.
// - Pin must stay active the whole hold time; only then reset fires.
// - Hold duration comes from the time field of the pin configuration register.
`timescale 1ns/1ps

module pprc_ctrl #(
	parameter int N_GPIO = 12,
	parameter int UNIT_PERIODS = pprc_pkg::HOLD_UNIT_RC_PERIODS,
	parameter int HOLD_CNT_W = 24
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Pins and slow oscillator
	input wire logic [N_GPIO-1:0] gpio_in,
	input wire logic slow_rc_oscillator,
	// Reset requests
	output logic hw_reset_req,
	output logic por_reset_req,
	output logic fixed_reset_pin_as_gpio
);

	// ----------------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------------
	logic [N_GPIO-1:0] gpio_meta;
	logic [N_GPIO-1:0] gpio_sync;
	logic rc_meta;
	logic rc_sync;
	logic rc_prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gpio_meta <= '0;
			gpio_sync <= '0;
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_prev <= 1'b0;
		end else begin
			gpio_meta <= gpio_in;
			gpio_sync <= gpio_meta;
			rc_meta <= slow_rc_oscillator;
			rc_sync <= rc_meta;
			rc_prev <= rc_sync;
		end
	end

	logic rc_tick;
	assign rc_tick = rc_sync && !rc_prev;

	// ----------------------------------------------------------------------
	// Bus slave and registers
	// ----------------------------------------------------------------------
	logic wr_pend;
	logic [pprc_pkg::ADDR_DEC_W-1:0] wr_addr;
	logic hw_reset_pin_off;
	logic [pprc_pkg::POR_SEL_W-1:0] por_sel;
	logic por_pol;
	logic [pprc_pkg::POR_TIME_W-1:0] por_time;
	logic next_wr_pend;
	logic [pprc_pkg::ADDR_DEC_W-1:0] next_wr_addr;
	logic next_hw_reset_pin_off;
	logic [pprc_pkg::POR_SEL_W-1:0] next_por_sel;
	logic next_por_pol;
	logic [pprc_pkg::POR_TIME_W-1:0] next_por_time;
	logic [31:0] next_hrdata;
	logic access;
	logic [pprc_pkg::ADDR_DEC_W-1:0] rd_addr;
	logic pin_active;
	logic [HOLD_CNT_W-1:0] hold_cnt;

	assign access = hsel && hready && (htrans == pprc_pkg::HTRANS_NONSEQ || htrans == pprc_pkg::HTRANS_SEQ);
	assign rd_addr = haddr[pprc_pkg::ADDR_DEC_W-1:0];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		next_wr_pend = access && hwrite;
		next_wr_addr = wr_addr;
		next_hw_reset_pin_off = hw_reset_pin_off;
		next_por_sel = por_sel;
		next_por_pol = por_pol;
		next_por_time = por_time;
		next_hrdata = hrdata;
		if (access && hwrite) begin
			next_wr_addr = rd_addr;
		end
		if (wr_pend) begin
			case (wr_addr)
				pprc_pkg::HW_RESET_CTRL_OFF: begin
					next_hw_reset_pin_off = hwdata[pprc_pkg::HW_RESET_PIN_OFF_BIT];
				end
				pprc_pkg::POR_PIN_CFG_OFF: begin
					next_por_sel = hwdata[pprc_pkg::POR_SEL_LSB +: pprc_pkg::POR_SEL_W];
					next_por_pol = hwdata[pprc_pkg::POR_POL_BIT];
					next_por_time = hwdata[pprc_pkg::POR_TIME_LSB +: pprc_pkg::POR_TIME_W];
				end
				default: begin
				end
			endcase
		end
		// Read data built from next values so a read right after a write sees it
		if (access && !hwrite) begin
			next_hrdata = 32'h0000_0000;
			case (rd_addr)
				pprc_pkg::HW_RESET_CTRL_OFF: begin
					next_hrdata[pprc_pkg::HW_RESET_PIN_OFF_BIT] = next_hw_reset_pin_off;
				end
				pprc_pkg::POR_PIN_CFG_OFF: begin
					next_hrdata[pprc_pkg::POR_SEL_LSB +: pprc_pkg::POR_SEL_W] = next_por_sel;
					next_hrdata[pprc_pkg::POR_POL_BIT] = next_por_pol;
					next_hrdata[pprc_pkg::POR_TIME_LSB +: pprc_pkg::POR_TIME_W] = next_por_time;
				end
				pprc_pkg::STATUS_OFF: begin
					next_hrdata[pprc_pkg::ST_PIN_ACTIVE_BIT] = pin_active;
					next_hrdata[pprc_pkg::ST_POR_REQ_BIT] = por_reset_req;
					next_hrdata[pprc_pkg::ST_HW_REQ_BIT] = hw_reset_req;
					next_hrdata[pprc_pkg::ST_FIXED_LEVEL_BIT] = gpio_sync[pprc_pkg::FIXED_RESET_PIN_IDX];
				end
				pprc_pkg::HOLD_COUNT_OFF: begin
					next_hrdata[HOLD_CNT_W-1:0] = hold_cnt;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hw_reset_pin_off <= pprc_pkg::HW_RESET_PIN_OFF_RST;
			por_sel <= pprc_pkg::POR_SEL_RST;
			por_pol <= pprc_pkg::POR_POL_RST;
			por_time <= pprc_pkg::POR_TIME_RST;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hw_reset_pin_off <= next_hw_reset_pin_off;
			por_sel <= next_por_sel;
			por_pol <= next_por_pol;
			por_time <= next_por_time;
			hrdata <= next_hrdata;
		end
	end

	// ----------------------------------------------------------------------
	// Fixed hardware reset pin
	// ----------------------------------------------------------------------
	logic next_hw_reset_req;
	logic next_as_gpio;

	always_comb begin
		// Only the fixed pin feeds this path; the pin is never remapped
		next_hw_reset_req = gpio_sync[pprc_pkg::FIXED_RESET_PIN_IDX] && !hw_reset_pin_off;
		next_as_gpio = hw_reset_pin_off;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hw_reset_req <= 1'b0;
			fixed_reset_pin_as_gpio <= 1'b0;
		end else begin
			hw_reset_req <= next_hw_reset_req;
			fixed_reset_pin_as_gpio <= next_as_gpio;
		end
	end

	// ----------------------------------------------------------------------
	// Pin power-on reset hold timer
	// ----------------------------------------------------------------------
	logic sel_level;
	logic [HOLD_CNT_W-1:0] target;
	logic [HOLD_CNT_W-1:0] next_hold_cnt;
	logic next_por_reset_req;

	always_comb begin
		sel_level = 1'b0;
		if (int'(por_sel) < N_GPIO) begin
			sel_level = gpio_sync[por_sel];
		end
	end

	assign pin_active = (int'(por_sel) < N_GPIO) && (sel_level == por_pol);
	assign target = HOLD_CNT_W'(por_time) * HOLD_CNT_W'(UNIT_PERIODS);

	always_comb begin
		next_hold_cnt = hold_cnt;
		if (!pin_active || por_time == '0) begin
			next_hold_cnt = '0;
		end else if (hold_cnt > target) begin
			// A shortened time caps the count instead of leaving it above the new target
			next_hold_cnt = target;
		end else if (rc_tick && hold_cnt < target) begin
			next_hold_cnt = hold_cnt + HOLD_CNT_W'(1);
		end
		// Fires only once the whole hold time has been counted
		next_por_reset_req = pin_active && por_time != '0 && next_hold_cnt >= target;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt <= '0;
			por_reset_req <= 1'b0;
		end else begin
			hold_cnt <= next_hold_cnt;
			por_reset_req <= next_por_reset_req;
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_fixed_pin_only;
		hw_reset_req |-> $past(gpio_sync[pprc_pkg::FIXED_RESET_PIN_IDX]);
	endproperty
	a_fixed_pin_only: assert property (p_fixed_pin_only) else $error("hw reset without fixed pin");

	property p_pin_off_ignored;
		hw_reset_pin_off ##1 hw_reset_pin_off |-> !hw_reset_req;
	endproperty
	a_pin_off_ignored: assert property (p_pin_off_ignored) else $error("hw reset while pin disabled");

	property p_select_pin;
		por_reset_req |-> $past(int'(por_sel) < N_GPIO && gpio_sync[por_sel] == por_pol);
	endproperty
	a_select_pin: assert property (p_select_pin) else $error("por without selected pin");

	property p_polarity;
		(por_time != '0 && !pin_active) |=> !por_reset_req;
	endproperty
	a_polarity: assert property (p_polarity) else $error("por at inactive level");

	property p_hold_bound;
		hold_cnt <= target || $changed(por_time);
	endproperty
	a_hold_bound: assert property (p_hold_bound) else $error("hold counter beyond target");

	property p_full_hold;
		$rose(por_reset_req) |-> hold_cnt == target && target != '0;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("por before full hold");

	property p_time_zero;
		(por_time == '0) [*2] |-> !por_reset_req;
	endproperty
	a_time_zero: assert property (p_time_zero) else $error("por with zero time");

	property p_restart;
		!pin_active |=> hold_cnt == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("hold counter not restarted");

	property p_hw_follow;
		(gpio_sync[pprc_pkg::FIXED_RESET_PIN_IDX] && !hw_reset_pin_off) |=> hw_reset_req;
	endproperty
	a_hw_follow: assert property (p_hw_follow) else $error("fixed pin press ignored");

	property p_as_gpio;
		fixed_reset_pin_as_gpio == $past(hw_reset_pin_off);
	endproperty
	a_as_gpio: assert property (p_as_gpio) else $error("pin release flag wrong");

	property p_sel_range;
		int'(por_sel) >= N_GPIO |-> !pin_active;
	endproperty
	a_sel_range: assert property (p_sel_range) else $error("absent pin seen active");

	property p_count_on_tick;
		hold_cnt > $past(hold_cnt) |-> $past(rc_tick && pin_active);
	endproperty
	a_count_on_tick: assert property (p_count_on_tick) else $error("hold count without slow tick");

	property p_req_stays;
		(por_reset_req && pin_active && $stable(por_time)) |=> por_reset_req;
	endproperty
	a_req_stays: assert property (p_req_stays) else $error("por dropped while pin held");

endmodule

/* pprc_pkg.sv */
/*
 * Constants for the pin reset and pin power-on reset controller: register offsets,
 * field positions, reset values and the unit of the hold time.
 * Assumes a 32-bit AHB-Lite register bus and a 10 MHz bus clock.
 */
package pprc_pkg;

	// ----------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------------
	localparam logic [7:0] HW_RESET_CTRL_OFF = 8'h00;
	localparam logic [7:0] POR_PIN_CFG_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] HOLD_COUNT_OFF = 8'h0c;
	localparam int ADDR_DEC_W = 8;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int HW_RESET_PIN_OFF_BIT = 0;
	localparam int POR_SEL_LSB = 0;
	localparam int POR_SEL_W = 4;
	localparam int POR_POL_BIT = 4;
	localparam int POR_TIME_LSB = 8;
	localparam int POR_TIME_W = 8;
	localparam int ST_PIN_ACTIVE_BIT = 0;
	localparam int ST_POR_REQ_BIT = 1;
	localparam int ST_HW_REQ_BIT = 2;
	localparam int ST_FIXED_LEVEL_BIT = 3;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic HW_RESET_PIN_OFF_RST = 1'b0;
	localparam logic [POR_SEL_W-1:0] POR_SEL_RST = 4'h0;
	localparam logic POR_POL_RST = 1'b1;
	localparam logic [POR_TIME_W-1:0] POR_TIME_RST = 8'h00;

	// ----------------------------------------------------------------------
	// Timing and fixed reset pin
	// ----------------------------------------------------------------------
	localparam int BUS_CLK_PERIOD_NS = 100;
	localparam int HOLD_UNIT_RC_PERIODS = 4096;
	localparam int FIXED_RESET_PIN_IDX = 0;

	// AHB-Lite transfer types
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

/* tb_top.sv */
/*
 * Self-checking bench for the pin reset controller.
 * Assumes one AHB-Lite slave, a slow oscillator of 8 bus clocks, UNIT_PERIODS of 4.
 */
`timescale 1ns/1ps

module tb_top;
	localparam int U = 4;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, press, act, hw_req, por_req, pin_free;
	logic rc = 1'b0;
	logic [1:0] htrans;
	logic [1:0] rc_div = 2'h0;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0] pin_sel;
	logic [11:0] gpio;
	int fail_count = 0;
	int checks_done = 0;

	// ----------------------------------------------------------------------
	// Clock, slow oscillator, instances
	// ----------------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		rc_div <= rc_div + 2'h1;
		if (rc_div == 2'h3) begin
			rc <= ~rc;
		end
	end
	pprc_ctrl #(.N_GPIO(12), .UNIT_PERIODS(U), .HOLD_CNT_W(24)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio),
		.slow_rc_oscillator(rc), .hw_reset_req(hw_req), .por_reset_req(por_req),
		.fixed_reset_pin_as_gpio(pin_free));
	pprc_button #(.N_GPIO(12)) i_button (.press(press), .pin_sel(pin_sel), .active_high(act), .gpio(gpio));

	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= pprc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic pin(input logic p, input logic [3:0] s, input logic a);
		press <= p;
		pin_sel <= s;
		act <= a;
	endtask
	// Hold a press for the programmed time; no request one period early, request two periods after
	task automatic t_por(input logic [31:0] cfg, input int t, input logic a);
		pin(1'b0, cfg[3:0], a);
		repeat (4) @(posedge hclk);
		xfer(1'b1, 32'h04, cfg);
		pin(1'b1, cfg[3:0], a);
		repeat (8 * t * U - 8) @(posedge hclk);
		check(por_req, 1'b0);
		repeat (24) @(posedge hclk);
		check(por_req, 1'b1);
		rd_chk(32'h0c, 32'(t * U));
		rd_chk(32'h08, a ? 32'h3 : 32'hb);
		pin(1'b0, cfg[3:0], a);
		repeat (8) @(posedge hclk);
		check(por_req, 1'b0);
	endtask

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_regs;
		rd_chk(32'h00, 32'h0);
		rd_chk(32'h04, 32'h10);
		rd_chk(32'h20, 32'h0);
		xfer(1'b1, 32'h04, 32'hffffffff);
		rd_chk(32'h04, 32'h0000ff1f);
		check(hresp, 1'b0);
	endtask
	task automatic t_hw;
		pin(1'b1, 4'h0, 1'b1);
		repeat (5) @(posedge hclk);
		check(hw_req, 1'b1);
		rd_chk(32'h08, 32'hc);
		pin(1'b1, 4'h7, 1'b1);
		repeat (5) @(posedge hclk);
		check(hw_req, 1'b0);
		pin(1'b1, 4'h0, 1'b1);
		xfer(1'b1, 32'h00, 32'h1);
		repeat (5) @(posedge hclk);
		check(hw_req, 1'b0);
		check(pin_free, 1'b1);
		pin(1'b0, 4'h0, 1'b1);
		repeat (4) @(posedge hclk);
	endtask
	// Interrupted press must start the hold count afresh
	task automatic t_glitch;
		pin(1'b0, 4'h5, 1'b1);
		repeat (4) @(posedge hclk);
		xfer(1'b1, 32'h04, 32'h0215);
		pin(1'b1, 4'h5, 1'b1);
		repeat (48) @(posedge hclk);
		pin(1'b0, 4'h5, 1'b1);
		repeat (4) @(posedge hclk);
		pin(1'b1, 4'h5, 1'b1);
		repeat (48) @(posedge hclk);
		check(por_req, 1'b0);
		pin(1'b0, 4'h5, 1'b1);
		repeat (8) @(posedge hclk);
	endtask

	// ----------------------------------------------------------------------
	// Sequence, watchdog, verdict
	// ----------------------------------------------------------------------
	task automatic results;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		press = 1'b0;
		pin_sel = 4'h0;
		act = 1'b1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_hw;
		t_por(32'h0215, 2, 1'b1);
		t_por(32'h0103, 1, 1'b0);
		t_glitch;
		results;
	end
	initial begin
		#2000000;
		fail_count++;
		results;
	end
endmodule
